// ### verilog/smart_card_uart_event_regs.sv
// Event flags, enables, selection register and transmit buffer of the card UART
// Notes on behaviour
// - Flag bit 7 sets when the transmit buffer moves into the shift register.
// - Identification page is read-only; reading it clears every flag except one whose event arrives in the same cycle.
// - Flag bit 5 sets when card current leaves its allowed range.
// - Flag bit 4 sets when card supply leaves the selected voltage range.
// - Flag bit 2 sets when a character has been sent.
// - Flag bit 1 sets when a character has been received.
// - Parity flag bit 0 sets together with the sent or received flag.
// - Enable bits 7 and 5..0 gate matching flags; one allows, zero blocks.
// - Identify and enable share one address; page bit picks, zero identify.
// - Repeat select clear gives five repetitions, set gives four.
// - Divider field bits 3-2 divides by 1, 2, 4, 8; reset is divide-by-4.
// - Pin select set drives divided clock on the pin, else port function.
// - Buffer write with page bit clear clears empty status; move into shift register sets it and wins over a write.
`timescale 1ns/1ps
module smart_card_uart_event_regs
  import card_event_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire sfr_access_t sfr,
  input wire card_events_t events,
  input wire logic card_clk_tick,
  input wire logic port_pin_out,
  output logic [7:0] sfr_rdata,
  output logic [7:0] tx_data,
  output logic txbuf_empty_status,
  output logic [2:0] repeat_count,
  output logic shared_pin_out,
  output logic card_irq
);
  logic [7:0] identify;
  logic [7:0] next_identify;
  logic [7:0] enable;
  logic [7:0] next_enable;
  logic [4:0] select_cfg;
  logic [4:0] next_select_cfg;
  logic [7:0] next_tx_data;
  logic next_txbuf_empty;
  logic [7:0] next_rdata;
  logic [2:0] next_repeat_count;
  logic next_shared_pin;
  logic next_irq;
  logic [7:0] event_bits;
  logic page_enable;
  logic alt_clock;
  logic id_read;

  assign page_enable = select_cfg[BIT_PAGE_SELECT];
  assign id_read = sfr.rd && sfr.addr == ADDR_EVENT_PAGE && !page_enable;

  // Map event strobes onto identification bit positions
  always_comb begin
    event_bits = '0;
    event_bits[BIT_TXBUF_MOVED] = events.txbuf_moved;
    event_bits[BIT_CURRENT_FAULT] = events.current_fault;
    event_bits[BIT_VOLTAGE_FAULT] = events.voltage_fault;
    event_bits[BIT_WAIT_TIMEOUT] = events.wait_timeout;
    event_bits[BIT_CHAR_SENT] = events.char_sent;
    event_bits[BIT_CHAR_RECEIVED] = events.char_received;
    event_bits[BIT_PARITY_FAULT] = events.parity_fault &&
      (events.char_sent || events.char_received);
  end

  // Register writes, clear-on-read and buffer status; a new event wins over the clear
  always_comb begin
    next_identify = id_read ? RST_EVENT : identify;
    next_identify = next_identify | event_bits;
    next_enable = enable;
    next_select_cfg = select_cfg;
    next_tx_data = tx_data;
    next_txbuf_empty = txbuf_empty_status;
    if (sfr.wr) begin
      if (sfr.addr == ADDR_SELECT_CONFIG) begin
        next_select_cfg = sfr.wdata[4:0];
      end else if (sfr.addr == ADDR_EVENT_PAGE && page_enable) begin
        next_enable = sfr.wdata & EVENT_MASK;
      end else if (sfr.addr == ADDR_TX_BUFFER && !page_enable) begin
        next_tx_data = sfr.wdata;
        next_txbuf_empty = 1'b0;
      end
    end
    if (events.txbuf_moved) begin
      next_txbuf_empty = 1'b1;
    end
  end

  // Read data multiplexer for the shared page address
  always_comb begin
    next_rdata = RST_DATA;
    if (sfr.rd) begin
      if (sfr.addr == ADDR_SELECT_CONFIG) begin
        next_rdata = {3'b000, select_cfg};
      end else if (sfr.addr == ADDR_EVENT_PAGE && page_enable) begin
        next_rdata = enable;
      end else if (sfr.addr == ADDR_EVENT_PAGE) begin
        next_rdata = identify;
      end
    end
  end

  // Derived outputs: repetition count, pin function, interrupt request
  always_comb begin
    next_repeat_count = next_select_cfg[BIT_REPEAT_SELECT] ? REPEAT_FOUR : REPEAT_FIVE;
    next_shared_pin = select_cfg[BIT_ALT_PIN_SELECT] ? alt_clock : port_pin_out;
    next_irq = |(next_identify & next_enable);
  end

  alt_clock_divider_unit #(
    .WIDTH(3)
  ) u_divider (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_tick(card_clk_tick),
    .div_code(div_code_t'(select_cfg[BIT_DIV_HI:BIT_DIV_LO])),
    .clk_out(alt_clock)
  );

  // State and output registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      identify <= RST_EVENT;
      enable <= RST_EVENT;
      select_cfg <= RST_SELECT_CONFIG;
      tx_data <= RST_TX_BUFFER;
      txbuf_empty_status <= 1'b1;
      sfr_rdata <= RST_DATA;
      repeat_count <= REPEAT_FIVE;
      shared_pin_out <= 1'b0;
      card_irq <= 1'b0;
    end else begin
      identify <= next_identify;
      enable <= next_enable;
      select_cfg <= next_select_cfg;
      tx_data <= next_tx_data;
      txbuf_empty_status <= next_txbuf_empty;
      sfr_rdata <= next_rdata;
      repeat_count <= next_repeat_count;
      shared_pin_out <= next_shared_pin;
      card_irq <= next_irq;
    end
  end

  // Checks
  chk_txbuf_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
    events.txbuf_moved |=> identify[BIT_TXBUF_MOVED])
    else $error("transmit buffer flag not set");
  chk_read_clears_flags: assert property (@(posedge clk_sys) disable iff (rst)
    (id_read && !(|event_bits)) |=> identify == RST_EVENT)
    else $error("identify not cleared by read");
  chk_current_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
    events.current_fault |=> identify[BIT_CURRENT_FAULT])
    else $error("current fault flag not set");
  chk_voltage_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
    events.voltage_fault |=> identify[BIT_VOLTAGE_FAULT])
    else $error("voltage fault flag not set");
  chk_sent_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
    events.char_sent |=> identify[BIT_CHAR_SENT])
    else $error("sent flag not set");
  chk_recv_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
    events.char_received |=> identify[BIT_CHAR_RECEIVED])
    else $error("received flag not set");
  chk_parity_with_char: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(identify[BIT_PARITY_FAULT]) |-> identify[BIT_CHAR_SENT] ||
      identify[BIT_CHAR_RECEIVED])
    else $error("parity flag without character flag");
  chk_irq_follows_enable: assert property (@(posedge clk_sys) disable iff (rst)
    ((|(event_bits & enable)) && !sfr.wr) |=> card_irq)
    else $error("interrupt does not match flags and enables");
  chk_page_read_mux: assert property (@(posedge clk_sys) disable iff (rst)
    (sfr.rd && sfr.addr == ADDR_EVENT_PAGE && page_enable) |=> sfr_rdata == $past(enable))
    else $error("enable page read wrong");
  chk_repeat_count: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 repeat_count == (select_cfg[BIT_REPEAT_SELECT] ? REPEAT_FOUR : REPEAT_FIVE))
    else $error("repeat count wrong");
  chk_pin_port_mode: assert property (@(posedge clk_sys) disable iff (rst)
    !select_cfg[BIT_ALT_PIN_SELECT] |=> shared_pin_out == $past(port_pin_out))
    else $error("pin not in port mode");
  chk_buffer_empty_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (sfr.wr && sfr.addr == ADDR_TX_BUFFER && !page_enable && !events.txbuf_moved)
      |=> !txbuf_empty_status ##0 tx_data == $past(sfr.wdata))
    else $error("buffer write did not clear empty status");
  cov_irq_raised: cover property (@(posedge clk_sys) disable iff (rst) $rose(card_irq));
  cov_read_clear: cover property (@(posedge clk_sys) disable iff (rst)
    id_read ##1 identify == RST_EVENT);
  cov_alt_clock: cover property (@(posedge clk_sys) disable iff (rst)
    select_cfg[BIT_ALT_PIN_SELECT] ##1 $rose(shared_pin_out));
  cov_tx_cycle: cover property (@(posedge clk_sys) disable iff (rst)
    !txbuf_empty_status ##[1:20] txbuf_empty_status);
endmodule // smart_card_uart_event_regs

// ### shared/card_event_pkg.sv
// Package with register map, field positions and carrier types for the card event block
package card_event_pkg;
  // Special function register addresses
  localparam logic [7:0] ADDR_TX_BUFFER = 8'h00_AA;
  localparam logic [7:0] ADDR_SELECT_CONFIG = 8'h00_AB;
  localparam logic [7:0] ADDR_EVENT_PAGE = 8'h00_AE;
  // Reset values
  localparam logic [7:0] RST_TX_BUFFER = 8'h00_00;
  localparam logic [4:0] RST_SELECT_CONFIG = 5'h0_8;
  localparam logic [7:0] RST_EVENT = 8'h00_00;
  localparam logic [7:0] RST_DATA = 8'h00_00;
  // Identification and enable bit positions
  localparam int BIT_TXBUF_MOVED = 7;
  localparam int BIT_CURRENT_FAULT = 5;
  localparam int BIT_VOLTAGE_FAULT = 4;
  localparam int BIT_WAIT_TIMEOUT = 3;
  localparam int BIT_CHAR_SENT = 2;
  localparam int BIT_CHAR_RECEIVED = 1;
  localparam int BIT_PARITY_FAULT = 0;
  // Implemented bits of the event pages; bit 6 is reserved and reads zero
  localparam logic [7:0] EVENT_MASK = 8'h00_BF;
  // Selection register field positions
  localparam int BIT_REPEAT_SELECT = 4;
  localparam int BIT_DIV_HI = 3;
  localparam int BIT_DIV_LO = 2;
  localparam int BIT_ALT_PIN_SELECT = 1;
  localparam int BIT_PAGE_SELECT = 0;
  // Repetition counts before parity fault indication
  localparam logic [2:0] REPEAT_FIVE = 3'h5;
  localparam logic [2:0] REPEAT_FOUR = 3'h4;
  // Divider codes
  typedef enum logic [1:0] {
    DIV_1 = 2'b00,
    DIV_2 = 2'b01,
    DIV_4 = 2'b10,
    DIV_8 = 2'b11
  } div_code_t;
  // Hardware event strobes from the card UART, one cycle each
  typedef struct packed {
    logic txbuf_moved;
    logic current_fault;
    logic voltage_fault;
    logic wait_timeout;
    logic char_sent;
    logic char_received;
    logic parity_fault;
  } card_events_t;
  // Software access on the special function register port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sfr_access_t;
endpackage

// ### verilog/alt_clock_divider_unit.sv
// Prescaler that makes the alternate card clock from the card clock tick
`timescale 1ns/1ps
module alt_clock_divider_unit
  import card_event_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_tick,
  input wire div_code_t div_code,
  output logic clk_out
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic next_clk_out;
  logic toggle;

  // Toggle the output every 1, 2, 4 or 8 ticks (divide by 1 means toggle on every tick)
  always_comb begin
    next_count = count;
    toggle = 1'b0;
    if (clk_tick) begin
      next_count = count + WIDTH'(1);
      case (div_code)
        DIV_1: toggle = 1'b1;
        DIV_2: toggle = count[0];
        DIV_4: toggle = &count[1:0];
        default: toggle = &count[2:0];
      endcase
    end
    next_clk_out = toggle ? ~clk_out : clk_out;
  end

  // Register the counter and the clock level
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count <= '0;
      clk_out <= 1'b0;
    end else begin
      count <= next_count;
      clk_out <= next_clk_out;
    end
  end
endmodule // alt_clock_divider_unit

// ### verification/test_smart_card_uart_event_regs.sv
// Self-checking testbench for the card UART event registers
`timescale 1ns/1ps
module test_smart_card_uart_event_regs;
  import card_event_pkg::*;
  logic clk_sys;
  logic rst;
  sfr_access_t sfr;
  card_events_t events;
  logic card_clk_tick;
  logic port_pin_out;
  logic [7:0] sfr_rdata;
  logic [7:0] tx_data;
  logic txbuf_empty_status;
  logic [2:0] repeat_count;
  logic shared_pin_out;
  logic card_irq;
  logic prev;
  logic [7:0] got;
  logic [7:0] want;
  int n_mismatch;
  int num_checks;
  int span;

  smart_card_uart_event_regs DUT (.clk_sys(clk_sys), .rst(rst), .sfr(sfr), .events(events),
    .card_clk_tick(card_clk_tick), .port_pin_out(port_pin_out), .sfr_rdata(sfr_rdata),
    .tx_data(tx_data), .txbuf_empty_status(txbuf_empty_status), .repeat_count(repeat_count),
    .shared_pin_out(shared_pin_out), .card_irq(card_irq));

  // 100 ns clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Compare one byte-wide result
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Register write, strobe held over one rising edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr = {a, d, 1'b1, 1'b0};
    @(negedge clk_sys);
    sfr = '0;
  endtask

  // Register read, data taken in the cycle after the strobe edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    sfr = {a, 8'h00_00, 1'b0, 1'b1};
    @(negedge clk_sys);
    sfr = '0;
    d = sfr_rdata;
  endtask

  // One-cycle event pulse
  task automatic pulse(input card_events_t e);
    @(negedge clk_sys);
    events = e;
    @(negedge clk_sys);
    events = '0;
  endtask

  task automatic test_reset();
    rd_reg(ADDR_SELECT_CONFIG, got);
    chk("select reset", 8'h00_08, got);
    rd_reg(ADDR_EVENT_PAGE, got);
    chk("identify reset", 8'h00_00, got);
    chk("empty reset", 8'h00_01, {7'h0, txbuf_empty_status});
    chk("repeat reset", 8'h00_05, {5'h0, repeat_count});
  endtask

  // Each event alone, then read-clear, parity pairing and write refusal
  task automatic test_flags();
    for (int i = 0; i < 7; i++) begin
      pulse(card_events_t'(7'h01 << i));
      rd_reg(ADDR_EVENT_PAGE, got);
      // Lone parity strobe sets nothing; moved strobe lands on bit 7
      want = (i == 6) ? 8'h00_80 : ((i == 0) ? 8'h00_00 : 8'(1 << i));
      chk("identify flag", want, got);
      rd_reg(ADDR_EVENT_PAGE, got);
      chk("identify cleared", 8'h00_00, got);
    end
    // Status parity bit sits outside this block; its driver clears it after a status read
    pulse(card_events_t'(7'h05));
    rd_reg(ADDR_EVENT_PAGE, got);
    chk("parity with sent", 8'h00_05, got);
    pulse(card_events_t'(7'h03));
    rd_reg(ADDR_EVENT_PAGE, got);
    chk("parity with received", 8'h00_03, got);
    wr_reg(ADDR_EVENT_PAGE, 8'h00_FF);
    rd_reg(ADDR_EVENT_PAGE, got);
    chk("identify read only", 8'h00_00, got);
  endtask

  // Enable page, masking of the request and page-dependent buffer write
  task automatic test_enable();
    wr_reg(ADDR_SELECT_CONFIG, 8'h00_09);
    wr_reg(ADDR_EVENT_PAGE, 8'h00_FF);
    rd_reg(ADDR_EVENT_PAGE, got);
    chk("enable readback", 8'h00_BF, got);
    wr_reg(ADDR_EVENT_PAGE, 8'h00_02);
    wr_reg(ADDR_TX_BUFFER, 8'h00_5A);
    chk("buffer on page one", 8'h00_00, tx_data);
    pulse(card_events_t'(7'h04));
    chk("masked request", 8'h00_00, {7'h0, card_irq});
    pulse(card_events_t'(7'h02));
    chk("enabled request", 8'h00_01, {7'h0, card_irq});
    rd_reg(ADDR_EVENT_PAGE, got);
    chk("enable page read", 8'h00_02, got);
    wr_reg(ADDR_SELECT_CONFIG, 8'h00_08);
    rd_reg(ADDR_EVENT_PAGE, got);
    chk("identify page read", 8'h00_06, got);
    chk("request after clear", 8'h00_00, {7'h0, card_irq});
  endtask

  // Buffer write, move into shift register, repeat selection
  task automatic test_txbuf();
    chk("empty before write", 8'h00_01, {7'h0, txbuf_empty_status});
    wr_reg(ADDR_TX_BUFFER, 8'h00_A5);
    chk("buffer data", 8'h00_A5, tx_data);
    chk("empty after write", 8'h00_00, {7'h0, txbuf_empty_status});
    pulse(card_events_t'(7'h40));
    chk("empty after move", 8'h00_01, {7'h0, txbuf_empty_status});
    rd_reg(ADDR_EVENT_PAGE, got);
    chk("moved flag", 8'h00_80, got);
    wr_reg(ADDR_SELECT_CONFIG, 8'h00_F8);
    rd_reg(ADDR_SELECT_CONFIG, got);
    chk("select readback", 8'h00_18, got);
    chk("repeat four", 8'h00_04, {5'h0, repeat_count});
  endtask

  // Port function, then half period of the divided clock per code
  task automatic test_pin();
    wr_reg(ADDR_SELECT_CONFIG, 8'h00_08);
    port_pin_out = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("port high", 8'h00_01, {7'h0, shared_pin_out});
    port_pin_out = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("port low", 8'h00_00, {7'h0, shared_pin_out});
    for (int c = 0; c < 4; c++) begin
      wr_reg(ADDR_SELECT_CONFIG, {4'h0, c[1:0], 2'b10});
      card_clk_tick = 1'b1;
      repeat (2) begin
        prev = shared_pin_out;
        span = 0;
        do begin
          @(negedge clk_sys);
          span++;
        end while (shared_pin_out === prev && span < 40);
      end
      card_clk_tick = 1'b0;
      chk("alt clock half period", 8'(1 << c), span[7:0]);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    sfr = '0;
    events = '0;
    card_clk_tick = 1'b0;
    port_pin_out = 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    test_reset();
    test_flags();
    test_enable();
    test_txbuf();
    test_pin();
    wrap_up();
  end

  // Watchdog far beyond the fewer than 150 cycles the tests need
  initial begin
    #1000000;
    n_mismatch++;
    wrap_up();
  end
endmodule // test_smart_card_uart_event_regs
